// [rtl/hbmd_decoder.sv]
// Function
// - Mode 00 is phase/drive, 01 two-input PWM (reset), 10 independent, 11 outputs off.
// - A grounded strap gives phase/drive, a high one two-input PWM, the resistor independent.
// - The strap is captured only at power-up and on leaving sleep.
// - The strap is sampled only once the logic supply is up.
// - The serial variant takes its mode from the first control register.
// - The serial variant loads that mode at power-up and when disable falls.
// - Sleep or disable turns both outputs off; phase/drive follows drive and phase.
// - Two-input PWM maps 00 off, 01 A low B high, 10 A high B low, 11 both high.
// - Independent mode drives each output from its own input.
// - In independent mode an overcurrent on one half turns off only that half.
// - In independent mode a force-off bit, reset zero, turns its output off.
// - The pin variant has no per-output force-off.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ns

module hbmd_decoder (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_b,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output      logic                    pready,
    output      logic [31:0]             prdata,
    output      logic                    pslverr,
    input  wire logic                    low_power_request_n,
    input  wire logic                    bridge_disable,
    input  wire logic                    bridge_input_a,
    input  wire logic                    bridge_input_b,
    input  wire logic                    overcurrent_fault_a,
    input  wire logic                    overcurrent_fault_b,
    input  wire logic                    internal_logic_supply_ok,
    input  wire logic                    serial_variant,
    input  wire logic [1:0]              mode_strap,
    output      hbmd_pkg::hbmd_half_type bridge_output_a,
    output      hbmd_pkg::hbmd_half_type bridge_output_b,
    output      logic                    irq
);
    import hbmd_pkg::*;

    hbmd_state_type st;
    hbmd_state_type next_st;
    hbmd_pins_type  pins_async;
    hbmd_pins_type  pins;
    logic           rst_sync_b;

    // ------------------------------------------------------------------
    // Address decode and mode tables
    // ------------------------------------------------------------------
    function automatic logic [2:0] decode_addr(input logic [31:0] addr);
        logic [2:0] idx;
        idx = REG_UNMAPPED;
        if (addr == OFFSET_CONTROL_1) begin
            idx = REG_CONTROL_1;
        end else if (addr == OFFSET_STATE) begin
            idx = REG_STATE;
        end else if (addr == OFFSET_CONTROL_3) begin
            idx = REG_CONTROL_3;
        end else if (addr == OFFSET_EVENT_STATUS) begin
            idx = REG_EVENT_STATUS;
        end else if (addr == OFFSET_EVENT_MASK) begin
            idx = REG_EVENT_MASK;
        end
        return idx;
    endfunction

    function automatic logic [1:0] strap_to_mode(input logic [1:0] strap);
        logic [1:0] mode;
        mode = MODE_TWO_PWM;
        case (strap)
            STRAP_GROUND: begin
                mode = MODE_PHASE_DRIVE;
            end
            STRAP_HIGH: begin
                mode = MODE_TWO_PWM;
            end
            STRAP_RESISTOR: begin
                mode = MODE_INDEPENDENT;
            end
            default: begin
                mode = MODE_TWO_PWM;
            end
        endcase
        return mode;
    endfunction

    function automatic hbmd_bridge_type drive_bridge(input logic [1:0] mode,
                                                     input logic       in_a,
                                                     input logic       in_b);
        hbmd_bridge_type br;
        br = '0;
        case (mode)
            MODE_PHASE_DRIVE: begin
                br.a.enable = 1'b1;
                br.b.enable = 1'b1;
                br.a.level  = ~in_a | in_b;
                br.b.level  = ~in_a | ~in_b;
            end
            MODE_TWO_PWM: begin
                br.a.enable = in_a | in_b;
                br.b.enable = in_a | in_b;
                br.a.level  = in_a;
                br.b.level  = in_b;
            end
            MODE_INDEPENDENT: begin
                br.a.enable = 1'b1;
                br.b.enable = 1'b1;
                br.a.level  = in_a;
                br.b.level  = in_b;
            end
            default: begin
                br = '0;
            end
        endcase
        return br;
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    assign pins_async = {low_power_request_n, bridge_disable, bridge_input_a, bridge_input_b,
                         overcurrent_fault_a, overcurrent_fault_b, internal_logic_supply_ok,
                         serial_variant, mode_strap};

    hbmd_pin_sync u_pin_sync (
        .ref_clk     (ref_clk),
        .rst_sync_b  (rst_sync_b),
        .pins_async  (pins_async),
        .pins_stable (pins)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic                 setup;
        logic                 wr;
        logic [2:0]           idx;
        logic [EVT_WIDTH-1:0] events;
        logic [EVT_WIDTH-1:0] clear;
        logic                 sleep_rise;
        logic                 disable_fall;
        logic                 off_a;
        logic                 off_b;
        logic                 fault_any;
        hbmd_bridge_type      br;

        setup        = psel & ~penable;
        wr           = psel & penable & pwrite;
        idx          = decode_addr(paddr);
        events       = '0;
        clear        = '0;
        sleep_rise   = pins.low_power_request_n & ~st.prev_sleep_n;
        disable_fall = ~pins.bridge_disable & st.prev_disable;
        off_a        = 1'b0;
        off_b        = 1'b0;
        fault_any    = 1'b0;
        br           = '0;

        next_st              = st;
        next_st.rst_release  = st.rst_release;
        next_st.prev_sleep_n = pins.low_power_request_n;
        next_st.prev_disable = pins.bridge_disable;
        next_st.prev_fault_a = pins.overcurrent_fault_a;
        next_st.prev_fault_b = pins.overcurrent_fault_b;

        // Power-up and mode latching.
        case (st.power)
            PWR_WAIT_SUPPLY: begin
                if (pins.internal_logic_supply_ok) begin
                    next_st.power          = PWR_ACTIVE;
                    next_st.serial_variant = pins.serial_variant;
                    if (pins.serial_variant) begin
                        next_st.active_mode = st.mode_field;
                    end else begin
                        next_st.active_mode = strap_to_mode(pins.mode_strap);
                    end
                    events[EVT_MODE_LATCHED] = 1'b1;
                end
            end
            PWR_ACTIVE: begin
                if (!pins.internal_logic_supply_ok) begin
                    next_st.power = PWR_WAIT_SUPPLY;
                end else if (!st.serial_variant && sleep_rise) begin
                    next_st.active_mode      = strap_to_mode(pins.mode_strap);
                    events[EVT_MODE_LATCHED] = 1'b1;
                end else if (st.serial_variant && disable_fall) begin
                    next_st.active_mode      = st.mode_field;
                    events[EVT_MODE_LATCHED] = 1'b1;
                end
            end
            default: begin
                next_st.power = PWR_WAIT_SUPPLY;
            end
        endcase

        events[EVT_FAULT_A] = pins.overcurrent_fault_a & ~st.prev_fault_a;
        events[EVT_FAULT_B] = pins.overcurrent_fault_b & ~st.prev_fault_b;
        events[EVT_SLEEP]   = ~pins.low_power_request_n & st.prev_sleep_n;

        // Output decode from the synchronised inputs.
        br        = drive_bridge(st.active_mode, pins.bridge_input_a, pins.bridge_input_b);
        fault_any = pins.overcurrent_fault_a | pins.overcurrent_fault_b;
        if (st.active_mode == MODE_INDEPENDENT) begin
            off_a = pins.overcurrent_fault_a;
            off_b = pins.overcurrent_fault_b;
            if (st.serial_variant) begin
                off_a = off_a | st.force_off[FORCE_OFF_A_BIT];
                off_b = off_b | st.force_off[FORCE_OFF_B_BIT];
            end
        end else begin
            off_a = fault_any;
            off_b = fault_any;
        end
        if (!pins.low_power_request_n || pins.bridge_disable || st.power != PWR_ACTIVE) begin
            off_a = 1'b1;
            off_b = 1'b1;
        end
        next_st.bridge.a.enable = br.a.enable & ~off_a;
        next_st.bridge.b.enable = br.b.enable & ~off_b;
        next_st.bridge.a.level  = br.a.level & ~off_a;
        next_st.bridge.b.level  = br.b.level & ~off_b;

        // Writes land at the access edge.
        if (wr && pstrb[0]) begin
            if (idx == REG_CONTROL_1) begin
                next_st.mode_field = pwdata[MODE_FIELD_LSB +: 2];
            end else if (idx == REG_CONTROL_3) begin
                next_st.force_off[FORCE_OFF_A_BIT] = pwdata[FORCE_OFF_A_BIT];
                next_st.force_off[FORCE_OFF_B_BIT] = pwdata[FORCE_OFF_B_BIT];
            end else if (idx == REG_EVENT_STATUS) begin
                clear = pwdata[EVT_WIDTH-1:0];
            end else if (idx == REG_EVENT_MASK) begin
                next_st.mask = pwdata[EVT_WIDTH-1:0];
            end
        end
        next_st.status = (st.status & ~clear) | events;
        next_st.irq    = |(next_st.status & next_st.mask);

        // Read data are prepared in the setup cycle.
        if (setup) begin
            next_st.prdata  = '0;
            next_st.pslverr = 1'b0;
            if (idx == REG_CONTROL_1) begin
                next_st.prdata[MODE_FIELD_LSB +: 2] = st.mode_field;
            end else if (idx == REG_STATE) begin
                next_st.prdata[STATE_MODE_LSB +: 2]  = st.active_mode;
                next_st.prdata[STATE_SERIAL_BIT]     = st.serial_variant;
                next_st.prdata[STATE_POWERED_BIT]    = (st.power == PWR_ACTIVE);
                next_st.prdata[STATE_ENABLE_A_BIT]   = st.bridge.a.enable;
                next_st.prdata[STATE_ENABLE_B_BIT]   = st.bridge.b.enable;
                next_st.prdata[STATE_LEVEL_A_BIT]    = st.bridge.a.level;
                next_st.prdata[STATE_LEVEL_B_BIT]    = st.bridge.b.level;
            end else if (idx == REG_CONTROL_3) begin
                next_st.prdata[1:0] = st.force_off;
            end else if (idx == REG_EVENT_STATUS) begin
                next_st.prdata[EVT_WIDTH-1:0] = st.status;
            end else if (idx == REG_EVENT_MASK) begin
                next_st.prdata[EVT_WIDTH-1:0] = st.mask;
            end else begin
                next_st.pslverr = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_release;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_release <= 2'h0;
        end else begin
            rst_release <= {rst_release[0], 1'b1};
        end
    end

    assign rst_sync_b = rst_release[1];

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st                <= '0;
            st.power          <= PWR_WAIT_SUPPLY;
            st.mode_field     <= MODE_FIELD_RESET;
            st.active_mode    <= MODE_FIELD_RESET;
            st.force_off      <= FORCE_OFF_RESET;
            st.status         <= EVENT_RESET;
            st.mask           <= EVENT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign pready          = 1'b1;
    assign prdata          = st.prdata;
    assign pslverr         = st.pslverr;
    assign bridge_output_a = st.bridge.a;
    assign bridge_output_b = st.bridge.b;
    assign irq             = st.irq;

endmodule

// [rtl/hbmd_pkg.sv]
package hbmd_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] OFFSET_CONTROL_1    = 32'h0000_0000;
    localparam logic [31:0] OFFSET_STATE        = 32'h0000_0004;
    localparam logic [31:0] OFFSET_CONTROL_3    = 32'h0000_0008;
    localparam logic [31:0] OFFSET_EVENT_STATUS = 32'h0000_000C;
    localparam logic [31:0] OFFSET_EVENT_MASK   = 32'h0000_0010;

    localparam logic [2:0] REG_CONTROL_1    = 3'h0;
    localparam logic [2:0] REG_STATE        = 3'h1;
    localparam logic [2:0] REG_CONTROL_3    = 3'h2;
    localparam logic [2:0] REG_EVENT_STATUS = 3'h3;
    localparam logic [2:0] REG_EVENT_MASK   = 3'h4;
    localparam logic [2:0] REG_UNMAPPED     = 3'h7;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int MODE_FIELD_LSB      = 0;
    localparam int FORCE_OFF_A_BIT     = 0;
    localparam int FORCE_OFF_B_BIT     = 1;
    localparam int STATE_MODE_LSB      = 0;
    localparam int STATE_SERIAL_BIT    = 2;
    localparam int STATE_POWERED_BIT   = 3;
    localparam int STATE_ENABLE_A_BIT  = 4;
    localparam int STATE_ENABLE_B_BIT  = 5;
    localparam int STATE_LEVEL_A_BIT   = 6;
    localparam int STATE_LEVEL_B_BIT   = 7;

    localparam int EVT_MODE_LATCHED = 0;
    localparam int EVT_FAULT_A      = 1;
    localparam int EVT_FAULT_B      = 2;
    localparam int EVT_SLEEP        = 3;
    localparam int EVT_WIDTH        = 4;

    localparam logic [1:0] MODE_PHASE_DRIVE = 2'h0;
    localparam logic [1:0] MODE_TWO_PWM     = 2'h1;
    localparam logic [1:0] MODE_INDEPENDENT = 2'h2;
    localparam logic [1:0] MODE_INPUTS_OFF  = 2'h3;

    localparam logic [1:0] STRAP_GROUND   = 2'h0;
    localparam logic [1:0] STRAP_HIGH     = 2'h1;
    localparam logic [1:0] STRAP_RESISTOR = 2'h2;

    localparam logic [1:0]           MODE_FIELD_RESET = MODE_TWO_PWM;
    localparam logic [1:0]           FORCE_OFF_RESET  = 2'h0;
    localparam logic [EVT_WIDTH-1:0] EVENT_RESET      = 4'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic level;
    } hbmd_half_type;

    typedef struct packed {
        hbmd_half_type a;
        hbmd_half_type b;
    } hbmd_bridge_type;

    typedef struct packed {
        logic       low_power_request_n;
        logic       bridge_disable;
        logic       bridge_input_a;
        logic       bridge_input_b;
        logic       overcurrent_fault_a;
        logic       overcurrent_fault_b;
        logic       internal_logic_supply_ok;
        logic       serial_variant;
        logic [1:0] mode_strap;
    } hbmd_pins_type;

    localparam hbmd_pins_type PINS_RESET = 10'h000;

    typedef enum logic {
        PWR_WAIT_SUPPLY,
        PWR_ACTIVE
    } hbmd_power_type;

    typedef struct packed {
        hbmd_pins_type ff1;
        hbmd_pins_type ff2;
        hbmd_pins_type ff3;
        hbmd_pins_type stable;
    } hbmd_sync_state_type;

    typedef struct packed {
        logic [1:0]           rst_release;
        hbmd_power_type       power;
        logic                 serial_variant;
        logic [1:0]           mode_field;
        logic [1:0]           active_mode;
        logic [1:0]           force_off;
        logic [EVT_WIDTH-1:0] status;
        logic [EVT_WIDTH-1:0] mask;
        logic                 prev_sleep_n;
        logic                 prev_disable;
        logic                 prev_fault_a;
        logic                 prev_fault_b;
        hbmd_bridge_type      bridge;
        logic [31:0]          prdata;
        logic                 pslverr;
        logic                 irq;
    } hbmd_state_type;

endpackage

// [rtl/hbmd_pin_sync.sv]
`timescale 1ns/1ns

module hbmd_pin_sync (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_sync_b,
    input  wire hbmd_pkg::hbmd_pins_type pins_async,
    output      hbmd_pkg::hbmd_pins_type pins_stable
);
    import hbmd_pkg::*;

    hbmd_sync_state_type st;
    hbmd_sync_state_type next_st;

    // ------------------------------------------------------------------
    // A bit changes only once stages two and three agree.
    // ------------------------------------------------------------------
    always_comb begin
        next_st        = st;
        next_st.ff1    = pins_async;
        next_st.ff2    = st.ff1;
        next_st.ff3    = st.ff2;
        next_st.stable = (~(st.ff2 ^ st.ff3) & st.ff3) | ((st.ff2 ^ st.ff3) & st.stable);
    end

    always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st <= {PINS_RESET, PINS_RESET, PINS_RESET, PINS_RESET};
        end else begin
            st <= next_st;
        end
    end

    assign pins_stable = st.stable;

endmodule

// [tb/hbmd_decoder_sva.sv]
`timescale 1ns/1ns
module hbmd_decoder_sva (
    input wire logic                    ref_clk,
    input wire logic                    rst_b,
    input wire logic                    low_power_request_n,
    input wire logic                    bridge_disable,
    input wire logic                    bridge_input_a,
    input wire logic                    bridge_input_b,
    input wire logic                    overcurrent_fault_a,
    input wire logic                    overcurrent_fault_b,
    input wire logic                    internal_logic_supply_ok,
    input wire logic                    serial_variant,
    input wire logic [1:0]              mode_strap,
    input wire hbmd_pkg::hbmd_half_type bridge_output_a,
    input wire hbmd_pkg::hbmd_half_type bridge_output_b
);
    import hbmd_pkg::*;
    logic [3:0] up_count;
    logic [9:0] pins;
    assign pins = {low_power_request_n, bridge_disable, bridge_input_a, bridge_input_b, overcurrent_fault_a,
                   overcurrent_fault_b, internal_logic_supply_ok, serial_variant, mode_strap};
    // Quiet-output check waits for reset to settle.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            up_count <= 4'h0;
        else if (up_count != 4'hF)
            up_count <= up_count + 4'h1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    property p_sleep_off; !low_power_request_n [*6] |-> !bridge_output_a.enable && !bridge_output_b.enable; endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("outputs driven in sleep");
    property p_disable_off; bridge_disable [*6] |-> !bridge_output_a.enable && !bridge_output_b.enable; endproperty
    a_disable_off: assert property (p_disable_off) else $error("outputs driven while disabled");
    property p_pin_pair; (!serial_variant && !overcurrent_fault_a && !overcurrent_fault_b) [*6]
        |-> bridge_output_a.enable == bridge_output_b.enable; endproperty
    a_pin_pair: assert property (p_pin_pair) else $error("one half off alone in pin variant");
    property p_fault_a_off; overcurrent_fault_a [*6] |-> !bridge_output_a.enable; endproperty
    a_fault_a_off: assert property (p_fault_a_off) else $error("half A driven during its fault");
    property p_fault_b_off; overcurrent_fault_b [*6] |-> !bridge_output_b.enable; endproperty
    a_fault_b_off: assert property (p_fault_b_off) else $error("half B driven during its fault");
    property p_high_pair; (bridge_input_a && bridge_input_b) [*6] |-> !bridge_output_a.enable || bridge_output_a.level;
    endproperty
    a_high_pair: assert property (p_high_pair) else $error("A low with both inputs high");
    property p_low_high; (!bridge_input_a && bridge_input_b) [*6] |-> !bridge_output_b.enable || bridge_output_b.level;
    endproperty
    a_low_high: assert property (p_low_high) else $error("B low with inputs 01");
    property p_sync_quiet; (up_count == 4'hF && !serial_variant && $stable(pins)) [*8]
        |=> $stable({bridge_output_a, bridge_output_b}); endproperty
    a_sync_quiet: assert property (p_sync_quiet) else $error("outputs moved with quiet pins");
endmodule

bind hbmd_decoder hbmd_decoder_sva u_sva (
    .ref_clk(ref_clk), .rst_b(rst_b), .low_power_request_n(low_power_request_n), .bridge_disable(bridge_disable),
    .bridge_input_a(bridge_input_a), .bridge_input_b(bridge_input_b), .overcurrent_fault_a(overcurrent_fault_a),
    .overcurrent_fault_b(overcurrent_fault_b), .internal_logic_supply_ok(internal_logic_supply_ok),
    .serial_variant(serial_variant), .mode_strap(mode_strap), .bridge_output_a(bridge_output_a),
    .bridge_output_b(bridge_output_b)
);

// [tb/hbmd_ctrl_model.sv]
`timescale 1ns/1ns
module hbmd_ctrl_model (
    input  wire logic ref_clk,
    input  wire logic cmd_a,
    input  wire logic cmd_b,
    input  wire logic pwm_on,
    output logic      bridge_input_a,
    output logic      bridge_input_b
);
    logic [3:0] phase;
    initial begin
        phase = 4'h0;
        bridge_input_a = 1'b0;
        bridge_input_b = 1'b0;
    end
    // B swaps drive and brake every eight cycles.
    always @(posedge ref_clk) begin
        phase <= phase + 4'h1;
        bridge_input_a <= cmd_a;
        bridge_input_b <= (pwm_on && phase[3]) ? 1'b1 : cmd_b;
    end
endmodule

// [tb/hbmd_decoder_test.sv]
`timescale 1ns/1ns
`define CHECK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin fail_count++; $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end

module hbmd_decoder_test;
    import hbmd_pkg::*;
    logic          ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]   paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic          pready, pslverr, irq, err, in_a, in_b;
    logic          sleep_n = 1'b1, dis = 1'b0, fa = 1'b0, fb = 1'b0, supply = 1'b0, serial = 1'b0;
    logic          cmd_a = 1'b0, cmd_b = 1'b0, pwm_on = 1'b0;
    logic [1:0]    strap = STRAP_HIGH, mode = MODE_TWO_PWM, fo = 2'h0;
    logic [15:0]   lfsr = 16'h005D;
    hbmd_half_type out_a, out_b;
    int            fail_count = 0, num_checks = 0;

    always #4 ref_clk = ~ref_clk;

    hbmd_decoder dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .low_power_request_n(sleep_n), .bridge_disable(dis), .bridge_input_a(in_a), .bridge_input_b(in_b),
        .overcurrent_fault_a(fa), .overcurrent_fault_b(fb), .internal_logic_supply_ok(supply),
        .serial_variant(serial), .mode_strap(strap), .bridge_output_a(out_a), .bridge_output_b(out_b), .irq(irq));
    hbmd_ctrl_model ctrl (.ref_clk(ref_clk), .cmd_a(cmd_a), .cmd_b(cmd_b), .pwm_on(pwm_on),
        .bridge_input_a(in_a), .bridge_input_b(in_b));

    // Expected {A enable, A level, B enable, B level}.
    function automatic logic [3:0] exp_out();
        logic [3:0] r;
        if (!sleep_n || dis || mode == MODE_INPUTS_OFF)
            return 4'h0;
        if (mode != MODE_INDEPENDENT) begin
            if (fa || fb)
                return 4'h0;
            if (mode == MODE_PHASE_DRIVE)
                return !cmd_a ? 4'hF : (cmd_b ? 4'hE : 4'hB);
            return (cmd_a && cmd_b) ? 4'hF : (cmd_a ? 4'hE : (cmd_b ? 4'hB : 4'h0));
        end
        r = {1'b1, cmd_a, 1'b1, cmd_b};
        if (fa || (serial && fo[0]))
            r[3:2] = 2'h0;
        if (fb || (serial && fo[1]))
            r[1:0] = 2'h0;
        return r;
    endfunction

    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        for (int n = 0; n < 16 && pready !== 1'b1; n++)
            @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check_reg(input logic [31:0] addr, input logic [31:0] msk, input logic [31:0] ex, input string nm);
        apb(1'b0, addr, 32'h0);
        `CHECK(nm, ex, rd & msk)
    endtask

    task automatic rand_step(input int n, input logic slp);
        repeat (n) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
            @(posedge ref_clk);
            cmd_a <= lfsr[0];
            cmd_b <= lfsr[1];
            fa <= &lfsr[4:2];
            fb <= &lfsr[7:5];
            dis <= &lfsr[9:8];
            sleep_n <= ~(slp & (&lfsr[12:10]));
            repeat (9) @(posedge ref_clk);
            #1;
            `CHECK("bridge outputs", exp_out(), {out_a, out_b})
        end
    endtask

    task automatic pulse_dis();
        @(posedge ref_clk);
        dis <= 1'b1;
        repeat (8) @(posedge ref_clk);
        dis <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #320000;
        fail_count++;
        $display("FAIL watchdog expected done seen hang");
        finish_test();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check_reg(OFFSET_CONTROL_1, 32'h3, 32'h1, "control_1 reset");
        check_reg(OFFSET_CONTROL_3, 32'h3, 32'h0, "control_3 reset");
        check_reg(OFFSET_EVENT_MASK, 32'hF, 32'h0, "mask reset");
        check_reg(OFFSET_STATE, 32'h8, 32'h0, "powered early");
        check_reg(32'h0000_0040, 32'hFFFFFFFF, 32'h0, "unmapped read");
        `CHECK("unmapped error", 1'b1, err)
        `CHECK("outputs early", 4'h0, {out_a, out_b})
        supply <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            @(posedge ref_clk);
            strap <= s[1:0];
            sleep_n <= 1'b0;
            repeat (8) @(posedge ref_clk);
            sleep_n <= 1'b1;
            mode = s[1:0];
            rand_step(12, 1'b1);
            check_reg(OFFSET_STATE, 32'hF, 32'h8 | 32'(s), "strap mode");
        end
        strap <= STRAP_GROUND;
        apb(1'b1, OFFSET_CONTROL_3, 32'h3);
        fo = 2'h3;
        rand_step(4, 1'b0);
        check_reg(OFFSET_STATE, 32'h3, 32'h2, "strap ignored");
        @(posedge ref_clk);
        serial <= 1'b1;
        supply <= 1'b0;
        repeat (8) @(posedge ref_clk);
        supply <= 1'b1;
        mode = MODE_TWO_PWM;
        rand_step(4, 1'b1);
        check_reg(OFFSET_STATE, 32'h7, 32'h5, "serial mode");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, OFFSET_CONTROL_1, 32'((m + 3) % 4));
            check_reg(OFFSET_STATE, 32'h3, 32'(mode), "mode held");
            pulse_dis();
            mode = 2'((m + 3) % 4);
            rand_step(10, 1'b1);
        end
        for (int f = 0; f < 4; f++) begin
            apb(1'b1, OFFSET_CONTROL_3, 32'(f));
            fo = 2'(f);
            rand_step(4, 1'b1);
        end
        cmd_a <= 1'b1;
        cmd_b <= 1'b0;
        pwm_on <= 1'b1;
        repeat (64) @(posedge ref_clk);
        pwm_on <= 1'b0;
        apb(1'b1, OFFSET_EVENT_STATUS, 32'hF);
        pulse_dis();
        check_reg(OFFSET_EVENT_STATUS, 32'h1, 32'h1, "latch event");
        `CHECK("irq masked", 1'b0, irq)
        apb(1'b1, OFFSET_EVENT_MASK, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1;
        `CHECK("irq raised", 1'b1, irq)
        apb(1'b1, OFFSET_EVENT_STATUS, 32'h1);
        repeat (2) @(posedge ref_clk);
        #1;
        `CHECK("irq cleared", 1'b0, irq)
        finish_test();
    end
endmodule
